// *** imvu_defs.vh ***
// constants for the interrupt mask and vector unit
// Notes on behaviour
// - masked source still posts, never goes pending
// - posting ignores the upper mask bits
// - mask bit 5 gates usb wakeup
// - mask bits 4..0 gate endpoints 8..4
// - soft post select steers clear-register writes
// - vector read gives lowest pending vector byte
// - nothing pending reads as zero
// - serviced interrupt leaves the pending set
// - any vector write with lane 0 on clears all posted
// - select clear: written zero clears posted
// - select set: written one posts interrupt
`ifndef IMVU_DEFS_VH
`define IMVU_DEFS_VH

// source count and field widths
`define IMVU_NSRC 6
`define IMVU_SRC_W 3
`define IMVU_ADDR_W 12
`define IMVU_IDX_W 10
`define IMVU_STAT_W 2

// register indices; byte address is four times the index
`define IMVU_IDX_CLEAR 10'h0DC
`define IMVU_IDX_MASK 10'h0DE
`define IMVU_IDX_SWEN 10'h0E1
`define IMVU_IDX_VEC 10'h0E2
`define IMVU_IDX_ISTAT 10'h0F0
`define IMVU_IDX_IMASK 10'h0F1

// reset values
`define IMVU_RST_MASK 6'h00
`define IMVU_RST_SWEN 1'h0
`define IMVU_RST_STAT 2'h0
`define IMVU_RST_VEC 8'h00
`define IMVU_RST_WORD 32'h00000000
`define IMVU_RST_STRB 4'h0

// field positions
`define IMVU_SWEN_BIT 0
`define IMVU_STAT_PEND 0
`define IMVU_STAT_CLRALL 1

// vector low bytes, index 0 (endpoint 4) has top priority
`define IMVU_VEC_NONE 8'h00
`define IMVU_VEC_EP4 8'h40
`define IMVU_VEC_EP5 8'h44
`define IMVU_VEC_EP6 8'h48
`define IMVU_VEC_EP7 8'h4C
`define IMVU_VEC_EP8 8'h50
`define IMVU_VEC_WAKE 8'h54

// bus responses
`define IMVU_RESP_OKAY 2'h0
`define IMVU_RESP_SLVERR 2'h2

`endif

// *** imvu_post_cell.v ***
// one posted-interrupt flag with set-wins-over-clear
`timescale 1ns/1ps
`default_nettype none

module imvu_post_cell (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // set requests
  input wire hw_post,
  input wire sw_post,
  // clear requests
  input wire sw_clear,
  input wire ack_clear,
  input wire all_clear,
  // flag
  output reg posted
);

  // any post request this cycle
  wire set_req;
  // any clear request this cycle
  wire clr_req;

  assign set_req = hw_post | sw_post;
  assign clr_req = sw_clear | ack_clear | all_clear;

  // flag update; a post beats a clear so no request is lost
  always @(posedge aclk) begin
    if (!aresetn) begin
      posted <= 1'b0;
    end else if (set_req) begin
      // set wins
      posted <= 1'b1;
    end else if (clr_req) begin
      posted <= 1'b0;
    end
  end

endmodule // imvu_post_cell

`default_nettype wire

// *** imvu_prio_enc.v ***
// fixed-priority encoder from pending flags to vector byte
`timescale 1ns/1ps
`default_nettype none
`include "imvu_defs.vh"

module imvu_prio_enc (
  // pending flags
  input wire [`IMVU_NSRC-1:0] pending,
  // winner
  output reg [7:0] vector,
  output reg [`IMVU_NSRC-1:0] winner
);

  // vector byte of one source index
  function [7:0] vec_of;
    input [`IMVU_SRC_W-1:0] idx;
    begin
      case (idx)
        3'h0: vec_of = `IMVU_VEC_EP4;
        3'h1: vec_of = `IMVU_VEC_EP5;
        3'h2: vec_of = `IMVU_VEC_EP6;
        3'h3: vec_of = `IMVU_VEC_EP7;
        3'h4: vec_of = `IMVU_VEC_EP8;
        3'h5: vec_of = `IMVU_VEC_WAKE;
        default: vec_of = `IMVU_VEC_NONE;
      endcase
    end
  endfunction

  integer i;

  // scan low priority upward so the lowest index ends as winner
  always @* begin
    vector = `IMVU_VEC_NONE;
    winner = {`IMVU_NSRC{1'b0}};
    for (i = `IMVU_NSRC - 1; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        vector = vec_of(i[`IMVU_SRC_W-1:0]);
        winner = {`IMVU_NSRC{1'b0}};
        winner[i] = 1'b1;
      end
    end
  end

endmodule // imvu_prio_enc

`default_nettype wire

// *** imvu_top.v ***
// interrupt mask and vector unit with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "imvu_defs.vh"

module imvu_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire awvalid,
  output wire awready,
  input wire [`IMVU_ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  // axi4-lite write data
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // axi4-lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // axi4-lite read address
  input wire arvalid,
  output wire arready,
  input wire [`IMVU_ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  // axi4-lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // peripheral sources: bit 0 endpoint4 .. bit 4 endpoint8, bit 5 wakeup
  input wire [`IMVU_NSRC-1:0] src_post,
  output reg [`IMVU_NSRC-1:0] src_clear,
  // cpu core side
  output reg cpu_irq_req,
  output reg [7:0] cpu_vector,
  input wire cpu_ack,
  // summary interrupt
  output reg irq
);

  // software state
  reg [`IMVU_NSRC-1:0] upper_source_mask; // one unmasks
  reg soft_post_select; // steers clear-register writes
  reg [`IMVU_STAT_W-1:0] irq_status; // sticky events
  reg [`IMVU_STAT_W-1:0] irq_mask; // event enables

  // write channel holding registers
  reg aw_held;
  reg [`IMVU_ADDR_W-1:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // posted and pending flags
  wire [`IMVU_NSRC-1:0] posted;
  wire [`IMVU_NSRC-1:0] pending;
  wire [`IMVU_NSRC-1:0] winner;
  wire [7:0] enc_vector;
  reg pending_any_q; // for the rising-edge event

  // write strobes decoded from the held address
  wire do_write;
  wire lane0;
  wire wr_clear;
  wire wr_mask;
  wire wr_swen;
  wire wr_vec;
  wire wr_istat;
  wire wr_imask;
  wire wr_mapped;

  // per-source software post and clear
  wire [`IMVU_NSRC-1:0] sw_post;
  wire [`IMVU_NSRC-1:0] sw_clear;
  wire [`IMVU_NSRC-1:0] ack_clear;

  // event pulses
  wire ev_pend;
  wire ev_clrall;
  wire [`IMVU_STAT_W-1:0] ev_vec;
  reg [`IMVU_STAT_W-1:0] next_irq_status;

  // read mux result
  reg [7:0] rd_byte;
  reg rd_ok;

  // true when a byte address lands on the given register index
  function hit;
    input [`IMVU_ADDR_W-1:0] addr;
    input [`IMVU_IDX_W-1:0] idx;
    begin
      // low two address bits are ignored
      hit = (addr[`IMVU_ADDR_W-1:2] == idx);
    end
  endfunction

  // ------------------------------------------------------------
  // write path of the slave
  // ------------------------------------------------------------

  // address and data are taken independently and held
  assign awready = !aw_held;
  assign wready = !w_held;
  // write acts once both are held and the last answer is gone
  // hazard: a held pair waits while the last answer still stands
  assign do_write = aw_held & w_held & !bvalid;
  // registers are eight bits wide, so only lane 0 carries data
  assign lane0 = w_strb[0];
  // limitation: a write with lane 0 off is answered but lands nowhere

  // per-register write strobes, one hot at most
  assign wr_clear = do_write & lane0 & hit(aw_addr, `IMVU_IDX_CLEAR);
  assign wr_mask = do_write & lane0 & hit(aw_addr, `IMVU_IDX_MASK);
  assign wr_swen = do_write & lane0 & hit(aw_addr, `IMVU_IDX_SWEN);
  assign wr_vec = do_write & lane0 & hit(aw_addr, `IMVU_IDX_VEC);
  assign wr_istat = do_write & lane0 & hit(aw_addr, `IMVU_IDX_ISTAT);
  assign wr_imask = do_write & lane0 & hit(aw_addr, `IMVU_IDX_IMASK);
  // decoding for the response ignores the lanes
  assign wr_mapped = hit(aw_addr, `IMVU_IDX_CLEAR) | hit(aw_addr, `IMVU_IDX_MASK) |
                     hit(aw_addr, `IMVU_IDX_SWEN) | hit(aw_addr, `IMVU_IDX_VEC) |
                     hit(aw_addr, `IMVU_IDX_ISTAT) | hit(aw_addr, `IMVU_IDX_IMASK);

  // channel holding and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= {`IMVU_ADDR_W{1'b0}};
      w_held <= 1'b0;
      w_data <= `IMVU_RST_WORD;
      w_strb <= `IMVU_RST_STRB;
      bvalid <= 1'b0;
      bresp <= `IMVU_RESP_OKAY;
    end else begin
      // capture address
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      // capture data
      // the strobe decides later whether the write lands
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      // perform and answer
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `IMVU_RESP_OKAY : `IMVU_RESP_SLVERR;
      end else if (bvalid && bready) begin
        // answer taken by the master
        bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------

  // mask, select and event mask storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      upper_source_mask <= `IMVU_RST_MASK;
      soft_post_select <= `IMVU_RST_SWEN;
      irq_mask <= `IMVU_RST_STAT;
    end else begin
      if (wr_mask) begin
        upper_source_mask <= w_data[`IMVU_NSRC-1:0];
      end
      if (wr_swen) begin
        soft_post_select <= w_data[`IMVU_SWEN_BIT];
      end
      // event mask for the summary interrupt
      if (wr_imask) begin
        irq_mask <= w_data[`IMVU_STAT_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // posted flags, one cell per source
  // ------------------------------------------------------------

  assign sw_clear = (wr_clear && !soft_post_select) ?
                    ~w_data[`IMVU_NSRC-1:0] : {`IMVU_NSRC{1'b0}};
  assign sw_post = (wr_clear && soft_post_select) ?
                   w_data[`IMVU_NSRC-1:0] : {`IMVU_NSRC{1'b0}};
  // the winner is taken in the ack cycle, so a newer, higher source
  // posted meanwhile is the one dropped; the core should ack promptly
  // serviced source dropped
  assign ack_clear = cpu_ack ? winner : {`IMVU_NSRC{1'b0}};

  // one flag cell per source; the cell settles post against clear
  // a post in the clear-all cycle survives, so no request is lost
  genvar g;
  generate
    for (g = 0; g < `IMVU_NSRC; g = g + 1) begin : g_src
      imvu_post_cell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .hw_post(src_post[g]),
        .sw_post(sw_post[g]),
        .sw_clear(sw_clear[g]),
        .ack_clear(ack_clear[g]),
        .all_clear(wr_vec),
        .posted(posted[g])
      );
    end
  endgenerate

  assign pending = posted & upper_source_mask;

  imvu_prio_enc u_enc (
    .pending(pending),
    .vector(enc_vector),
    .winner(winner)
  );

  // ------------------------------------------------------------
  // cpu side and source clear lines
  // ------------------------------------------------------------

  // registered so the core sees clean levels; one cycle behind flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq_req <= 1'b0;
      cpu_vector <= `IMVU_RST_VEC;
      src_clear <= {`IMVU_NSRC{1'b0}};
      pending_any_q <= 1'b0;
    end else begin
      cpu_irq_req <= |pending;
      // vector as the core fetches it
      cpu_vector <= enc_vector;
      src_clear <= wr_vec ? {`IMVU_NSRC{1'b1}} : {`IMVU_NSRC{1'b0}};
      // remembers whether anything pended last cycle
      pending_any_q <= |pending;
    end
  end

  // ------------------------------------------------------------
  // sticky event status and summary interrupt
  // ------------------------------------------------------------

  // events: pending set became non-empty, or a clear-all write
  assign ev_pend = (|pending) & !pending_any_q;
  assign ev_clrall = wr_vec;
  assign ev_vec = {ev_clrall, ev_pend};

  // write one to clear, but a fresh event in the same cycle survives
  always @* begin
    next_irq_status = irq_status;
    // clear first, then let the events in
    if (wr_istat) begin
      next_irq_status = irq_status & ~w_data[`IMVU_STAT_W-1:0];
    end
    next_irq_status = next_irq_status | ev_vec;
  end

  // status flops and level interrupt
  // irq follows the next status so a fresh event shows at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `IMVU_RST_STAT;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // read path of the slave
  // ------------------------------------------------------------

  // one read at a time; address refused while data waits
  assign arready = !rvalid;

  // read mux; upper bits of the word read as zero
  always @* begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (hit(araddr, `IMVU_IDX_CLEAR)) begin
      // posted flags, masked or not
      rd_byte = {2'h0, posted};
    end else if (hit(araddr, `IMVU_IDX_MASK)) begin
      // mask bits, one unmasks
      rd_byte = {2'h0, upper_source_mask};
    end else if (hit(araddr, `IMVU_IDX_SWEN)) begin
      // select bit alone
      rd_byte = {7'h00, soft_post_select};
    end else if (hit(araddr, `IMVU_IDX_VEC)) begin
      rd_byte = enc_vector;
    end else if (hit(araddr, `IMVU_IDX_ISTAT)) begin
      // sticky events
      rd_byte = {6'h00, irq_status};
    end else if (hit(araddr, `IMVU_IDX_IMASK)) begin
      // event enables
      rd_byte = {6'h00, irq_mask};
    end else begin
      // unmapped: zero data, slave error
      rd_ok = 1'b0;
    end
  end

  // read data capture and hold until taken
  // state is sampled at the address edge, not when the data is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= `IMVU_RST_WORD;
      rresp <= `IMVU_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_ok ? `IMVU_RESP_OKAY : `IMVU_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // imvu_top

`default_nettype wire

// *** imvu_props.sv ***
// concurrent checks on the ports of the interrupt mask and vector unit
`timescale 1ns/1ps
`default_nettype none
`include "imvu_defs.vh"

module imvu_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [`IMVU_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [`IMVU_ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // sources and core
  input wire logic [`IMVU_NSRC-1:0] src_clear,
  input wire logic cpu_irq_req,
  input wire logic [7:0] cpu_vector
);
  logic [`IMVU_ADDR_W-1:0] wa_q; // last write address taken
  logic [`IMVU_ADDR_W-1:0] ra_q; // last read address taken
  logic ws_q; // low byte strobe of last write

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // decoded register map, low two address bits ignored
  function automatic logic mapped(input logic [`IMVU_ADDR_W-1:0] a);
    return a[`IMVU_ADDR_W-1:2] inside {`IMVU_IDX_CLEAR, `IMVU_IDX_MASK, `IMVU_IDX_SWEN,
      `IMVU_IDX_VEC, `IMVU_IDX_ISTAT, `IMVU_IDX_IMASK};
  endfunction

  // capture addresses, the answer comes cycles later
  always @(posedge aclk) begin
    if (awvalid && awready) wa_q <= awaddr;
    if (wvalid && wready) ws_q <= wstrb[0];
    if (arvalid && arready) ra_q <= araddr;
  end

  vec_none_a: assert property (cpu_irq_req == (cpu_vector != `IMVU_VEC_NONE))
    else $error("vector and request disagree");
  clear_all_a: assert property ($rose(bvalid) && ws_q && wa_q == {`IMVU_IDX_VEC, 2'b00}
    |-> ##[0:1] src_clear == {`IMVU_NSRC{1'b1}})
    else $error("vector write left a source uncleared");
  clear_pulse_a: assert property (src_clear != 0 |=> src_clear == 0)
    else $error("clear lines held too long");
  b_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
    else $error("write answer late");
  r_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  wr_resp_a: assert property ($rose(bvalid) && wa_q[1:0] == 2'b00
    |-> bresp == (mapped(wa_q) ? `IMVU_RESP_OKAY : `IMVU_RESP_SLVERR))
    else $error("write response code wrong");
  rd_resp_a: assert property ($rose(rvalid) && ra_q[1:0] == 2'b00
    |-> rresp == (mapped(ra_q) ? `IMVU_RESP_OKAY : `IMVU_RESP_SLVERR) && rdata[31:8] == 0)
    else $error("read response wrong");

  // main scenarios reached
  cover property (cpu_irq_req && cpu_vector == `IMVU_VEC_EP4);
  cover property (src_clear != 0);
  cover property ($rose(bvalid) && bresp == `IMVU_RESP_SLVERR);
endmodule // imvu_props
`default_nettype wire

// *** imvu_cpu_model.sv ***
// behavioural core that services a raised request after a set delay
`timescale 1ns/1ps
`default_nettype none

module imvu_cpu_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // service order from the bench
  input wire logic go,
  input wire logic [3:0] dly,
  // unit side
  input wire logic cpu_irq_req,
  output logic cpu_ack
);
  logic [4:0] cnt; // cycles left, zero when idle

  // one-cycle service pulse, prompt or slow as dly says
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 5'h00;
      cpu_ack <= 1'b0;
    end else if (go) begin
      cnt <= {1'b0, dly} + 5'h01;
      cpu_ack <= 1'b0;
    end else if (cnt == 5'h01) begin
      cnt <= 5'h00;
      // a core only services a request it sees
      cpu_ack <= cpu_irq_req;
    end else begin
      // idle or counting down, no service
      cpu_ack <= 1'b0;
      if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // imvu_cpu_model
`default_nettype wire

// *** interrupt_mask_vector_unit_tb.sv ***
// self-checking bench for the interrupt mask and vector unit
`timescale 1ns/1ps
`default_nettype none
`include "imvu_defs.vh"

module interrupt_mask_vector_unit_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpu_irq_req, cpu_ack, irq, go;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, dly;
  logic [1:0] bresp, rresp;
  logic [5:0] src_post, src_clear, r;
  logic [7:0] cpu_vector;
  logic [7:0] vt [6]; // vector per source
  logic [33:0] bq [$]; // expected write answers
  logic [33:0] rq [$]; // expected read answers
  int err_total, num_checks, cyc, i;

  imvu_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .src_post(src_post), .src_clear(src_clear),
    .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_ack(cpu_ack), .irq(irq));

  imvu_cpu_model core (.aclk(aclk), .aresetn(aresetn), .go(go), .dly(dly),
    .cpu_irq_req(cpu_irq_req), .cpu_ack(cpu_ack));

  // verdict and end of run
  task tally_and_finish;
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // compare one value
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // write one register, hold each channel until taken
  task automatic wr(input logic [9:0] x, input logic [7:0] d,
      input logic [1:0] er = `IMVU_RESP_OKAY);
    bq.push_back({32'h0, er});
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {x, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  // read one register, expected low byte noted
  task automatic rd(input logic [9:0] x, input logic [7:0] d,
      input logic [1:0] er = `IMVU_RESP_OKAY);
    rq.push_back({er, 24'h0, d});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {x, 2'b00};
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // pulse the source lines for one cycle
  task automatic post(input logic [5:0] v);
    @(posedge aclk);
    src_post <= v;
    @(posedge aclk);
    src_post <= 6'h00;
  endtask

  // settle a registered output
  task automatic pass2;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // answer monitor takes the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) check("bresp", {32'h0, bresp}, bq.pop_front());
    if (rvalid && rready) check("rdata", {rresp, rdata}, rq.pop_front());
  end

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h00;
    {awaddr, araddr, wdata, dly, src_post} = 66'h0;
    wstrb = 4'hF;
    vt = '{`IMVU_VEC_EP4, `IMVU_VEC_EP5, `IMVU_VEC_EP6, `IMVU_VEC_EP7, `IMVU_VEC_EP8,
      `IMVU_VEC_WAKE};
    void'($urandom(44));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values of every register
    rd(`IMVU_IDX_MASK, 8'h00);
    rd(`IMVU_IDX_SWEN, 8'h00);
    rd(`IMVU_IDX_VEC, 8'h00);
    rd(`IMVU_IDX_CLEAR, 8'h00);
    rd(`IMVU_IDX_ISTAT, 8'h00);
    rd(`IMVU_IDX_IMASK, 8'h00);
    // all masked: random sources post, nothing pends
    r = 6'($urandom % 63) + 6'h01;
    post(r);
    rd(`IMVU_IDX_CLEAR, {2'b00, r});
    rd(`IMVU_IDX_VEC, `IMVU_VEC_NONE);
    check("cpu_irq_req", {33'h0, cpu_irq_req}, 34'h0);
    post(6'h3F);
    // each mask bit alone opens its own source
    for (i = 0; i < 6; i++) begin
      wr(`IMVU_IDX_MASK, 8'h01 << i);
      rd(`IMVU_IDX_VEC, vt[i]);
    end
    wr(`IMVU_IDX_MASK, 8'h3F);
    rd(`IMVU_IDX_VEC, `IMVU_VEC_EP4);
    check("cpu_irq_req", {33'h0, cpu_irq_req}, 34'h1);
    check("cpu_vector", {26'h0, cpu_vector}, {26'h0, `IMVU_VEC_EP4});
    // a write with lane 0 off lands nowhere
    wstrb <= 4'hE;
    wr(`IMVU_IDX_MASK, 8'h00);
    wstrb <= 4'hF;
    rd(`IMVU_IDX_MASK, 8'h3F);
    // core services the top source after a random delay
    @(posedge aclk);
    go <= 1'b1;
    dly <= 4'($urandom % 8);
    @(posedge aclk);
    go <= 1'b0;
    repeat (12) @(posedge aclk);
    rd(`IMVU_IDX_VEC, `IMVU_VEC_EP5);
    check("cpu_vector", {26'h0, cpu_vector}, {26'h0, `IMVU_VEC_EP5});
    rd(`IMVU_IDX_CLEAR, 8'h3E);
    // select clear: zero clears, one leaves alone
    wr(`IMVU_IDX_CLEAR, 8'h3B);
    rd(`IMVU_IDX_CLEAR, 8'h3A);
    // select set: one posts, zero leaves alone
    wr(`IMVU_IDX_SWEN, 8'h01);
    rd(`IMVU_IDX_SWEN, 8'h01);
    wr(`IMVU_IDX_CLEAR, 8'h05);
    rd(`IMVU_IDX_CLEAR, 8'h3F);
    // a vector write of any value clears every posted flag
    wr(`IMVU_IDX_VEC, 8'($urandom));
    rd(`IMVU_IDX_CLEAR, 8'h00);
    rd(`IMVU_IDX_VEC, `IMVU_VEC_NONE);
    check("cpu_irq_req", {33'h0, cpu_irq_req}, 34'h0);
    check("cpu_vector", {26'h0, cpu_vector}, {26'h0, `IMVU_VEC_NONE});
    // sticky status, masked then unmasked then cleared
    rd(`IMVU_IDX_ISTAT, 8'h03);
    check("irq", {33'h0, irq}, 34'h0);
    wr(`IMVU_IDX_IMASK, 8'h03);
    pass2();
    check("irq", {33'h0, irq}, 34'h1);
    wr(`IMVU_IDX_ISTAT, 8'h03);
    rd(`IMVU_IDX_ISTAT, 8'h00);
    pass2();
    check("irq", {33'h0, irq}, 34'h0);
    // unmapped place refused
    rd(10'h100, 8'h00, `IMVU_RESP_SLVERR);
    wr(10'h100, 8'h5A, `IMVU_RESP_SLVERR);
    pass2();
    tally_and_finish();
  end
endmodule // interrupt_mask_vector_unit_tb

bind imvu_top imvu_props u_props (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wstrb(wstrb),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .src_clear(src_clear), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector));
`default_nettype wire
